// file: include/rscs_pkg.sv
package rscs_pkg;
   localparam int RSCS_NUM_PINS = 16;
   localparam int RSCS_PROTO_PIN = 9;
   localparam int RSCS_HOLD_PIN = 8;
   localparam int RSCS_IDX_W = 4;
   localparam int RSCS_NUM_OUTS = 12;
   localparam logic RSCS_PROTO_RST = 1'h1;
   localparam logic [3:0] RSCS_IDX_RST = 4'hf;
   localparam int RSCS_LOAD_CYC = 4;
   typedef enum logic [5:0] {
      RSCS_ST_RESET = 6'h01,
      RSCS_ST_DEFAULTS = 6'h02,
      RSCS_ST_LOAD = 6'h04,
      RSCS_ST_CLOCKS = 6'h08,
      RSCS_ST_PLL = 6'h10,
      RSCS_ST_RUN = 6'h20
   } rscs_state_t;
endpackage

// file: include/rscs_snap_if.sv
`timescale 1ns/1ps
interface rscs_snap_if #(parameter int W = 16);
   logic capture;
   logic [W-1:0] pins;
   logic [W-1:0] snap;
   modport owner (input capture, input pins, output snap);
   modport user (output capture, output pins, input snap);
endinterface

// file: verilog/rscs_snap.sv
`timescale 1ns/1ps
module rscs_snap
   import rscs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   rscs_snap_if.owner bus
);
   logic [$bits(bus.snap)-1:0] snap_q;
   // pins reset to pulled-up level; capture only once per reset
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         snap_q <= '1;
      end else if (bus.capture) begin
         snap_q <= bus.pins;
      end
   end
   assign bus.snap = snap_q;
endmodule

// file: verilog/rscs_top.sv
`timescale 1ns/1ps
module rscs_top
   import rscs_pkg::*;
#(
   parameter int NUM_PINS = RSCS_NUM_PINS,
   parameter int SEL_W = RSCS_IDX_W,
   parameter int NUM_OUTS = RSCS_NUM_OUTS
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // pins sampled at reset release
   input wire logic [NUM_PINS-1:0] i_gpio_pins,
   // strap function assignment from identity block
   input wire logic i_programmed,
   input wire logic [NUM_PINS-1:0] i_sel_assign,
   input wire logic [NUM_PINS-1:0] i_addr_assign,
   input wire logic [NUM_PINS-1:0] i_eedis_assign,
   // stored configuration loader
   input wire logic i_cfg_done,
   input wire logic i_cfg_csum_ok,
   // start-up progress
   input wire logic i_clocks_ready,
   input wire logic i_pll_locked,
   // serial port overwrite
   input wire logic i_sw_wr,
   input wire logic i_sw_main_i2c,
   input wire logic i_sw_addr_bit,
   // loaded configuration overwrite
   input wire logic i_cfg_wr,
   input wire logic i_cfg_main_i2c,
   input wire logic i_cfg_addr_bit,
   input wire logic [NUM_OUTS-1:0] i_cfg_out_en,
   input wire logic [NUM_PINS-1:0] i_cfg_gpio_out,
   // resulting configuration
   output logic o_main_is_i2c,
   output logic o_aux_is_i2c,
   output logic o_slave_addr_bit_two,
   output logic o_eeprom_search_en,
   output logic o_cfg_load_req,
   output logic [SEL_W-1:0] o_stored_config_set,
   output logic o_cfg_applied,
   output logic o_regs_default,
   output logic [NUM_OUTS-1:0] o_out_en,
   output logic [NUM_PINS-1:0] o_gpio_out_mode,
   output logic o_regulators_en,
   output logic o_pll_cal_start,
   output logic o_startup_done
);
   // pin synchroniser; first stage feeds only the second
   logic [NUM_PINS-1:0] pin_s1_q;
   logic [NUM_PINS-1:0] pin_s2_q;
   logic first_q;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
      end else begin
         pin_s1_q <= i_gpio_pins;
         pin_s2_q <= pin_s1_q;
      end
   end

   // capture on the first edge after the synchronised pins settle
   logic [1:0] rel_cnt_q;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rel_cnt_q <= 2'h0;
         first_q <= 1'h0;
      end else begin
         if (rel_cnt_q != 2'h2) begin
            rel_cnt_q <= rel_cnt_q + 2'h1;
         end
         first_q <= (rel_cnt_q == 2'h1);
      end
   end

   rscs_snap_if #(.W(NUM_PINS)) snap_bus ();
   assign snap_bus.capture = first_q;
   assign snap_bus.pins = pin_s2_q;
   rscs_snap u_snap (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .bus(snap_bus)
   );
   wire [NUM_PINS-1:0] snap = snap_bus.snap;

   // decode of strap functions from the snapshot
   logic [SEL_W-1:0] packed_idx;
   logic addr_bit;
   // only the first SEL_W assigned pins fit; a wider word needs a wider SEL_W
   always_comb begin
      int k;
      k = 0;
      packed_idx = '0;
      addr_bit = 1'h0;
      for (int p = 0; p < NUM_PINS; p++) begin
         if (i_sel_assign[p] && k < SEL_W) begin
            packed_idx[k] = snap[p];
            k = k + 1;
         end
         if (i_addr_assign[p]) begin
            addr_bit = snap[p];
         end
      end
   end
   wire no_sel = (i_sel_assign == '0);
   wire [SEL_W-1:0] dflt_idx = SEL_W'(snap[3:0]);
   wire [SEL_W-1:0] sel_idx = no_sel ? dflt_idx : packed_idx;
   wire eeprom_dis = |(snap & i_eedis_assign);

   // start-up sequencer
   // defaults get one cycle of their own so a load always lands on top of them
   rscs_state_t st_q;
   rscs_state_t st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         RSCS_ST_RESET: if (first_q) st_d = RSCS_ST_DEFAULTS;
         RSCS_ST_DEFAULTS: st_d = i_programmed ? RSCS_ST_LOAD : RSCS_ST_CLOCKS;
         RSCS_ST_LOAD: if (i_cfg_done) st_d = RSCS_ST_CLOCKS;
         RSCS_ST_CLOCKS: if (i_clocks_ready) st_d = RSCS_ST_PLL;
         RSCS_ST_PLL: if (i_pll_locked) st_d = RSCS_ST_RUN;
         RSCS_ST_RUN: st_d = RSCS_ST_RUN;
         default: st_d = RSCS_ST_RESET;
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= RSCS_ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // configuration registers: strap defaults, then overwrites
   wire in_defaults = (st_q == RSCS_ST_DEFAULTS);
   wire cfg_take = (st_q == RSCS_ST_LOAD) && i_cfg_done && i_cfg_csum_ok;
   logic main_i2c_q;
   logic addr_q;
   logic eesrch_q;
   logic [SEL_W-1:0] idx_q;
   logic applied_q;
   logic [NUM_OUTS-1:0] out_en_q;
   logic [NUM_PINS-1:0] gpio_mode_q;
   // software writes wait for run so a late loader cannot undo them
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         main_i2c_q <= RSCS_PROTO_RST;
         addr_q <= 1'h0;
         eesrch_q <= 1'h1;
         idx_q <= SEL_W'(RSCS_IDX_RST);
         applied_q <= 1'h0;
         out_en_q <= '0;
         gpio_mode_q <= '0;
      end else if (in_defaults) begin
         main_i2c_q <= snap[RSCS_PROTO_PIN];
         addr_q <= addr_bit;
         eesrch_q <= ~eeprom_dis;
         idx_q <= sel_idx;
         out_en_q <= '0;
         gpio_mode_q <= '0;
      end else if (cfg_take && i_cfg_wr) begin
         main_i2c_q <= i_cfg_main_i2c;
         addr_q <= i_cfg_addr_bit;
         out_en_q <= i_cfg_out_en;
         gpio_mode_q <= i_cfg_gpio_out;
         applied_q <= 1'h1;
      end else if (cfg_take) begin
         applied_q <= 1'h1;
      end else if (i_sw_wr && st_q == RSCS_ST_RUN) begin
         main_i2c_q <= i_sw_main_i2c;
         addr_q <= i_sw_addr_bit;
      end
   end

   assign o_main_is_i2c = main_i2c_q;
   assign o_aux_is_i2c = ~main_i2c_q;
   assign o_slave_addr_bit_two = addr_q;
   assign o_eeprom_search_en = eesrch_q;
   assign o_stored_config_set = idx_q;
   assign o_cfg_load_req = (st_q == RSCS_ST_LOAD);
   assign o_cfg_applied = applied_q;
   assign o_regs_default = ~applied_q;
   assign o_out_en = out_en_q;
   assign o_gpio_out_mode = gpio_mode_q;
   assign o_regulators_en = (st_q != RSCS_ST_RESET);
   assign o_pll_cal_start = (st_q == RSCS_ST_PLL);
   assign o_startup_done = (st_q == RSCS_ST_RUN);

   // checks: strap capture
   chk_snap_take: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      first_q |=> snap == $past(pin_s2_q))
      else $error("snapshot not taken from synchronised pins");

   chk_snap_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (st_q != RSCS_ST_RESET) && !first_q |=> $stable(snap))
      else $error("snapshot changed after capture");

   chk_idx_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      st_q == RSCS_ST_RUN |=> $stable(idx_q) && $stable(eesrch_q))
      else $error("strap settings moved while running");

   // checks: serial port straps
   chk_proto_strap: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults |=> (main_i2c_q == $past(snap[RSCS_PROTO_PIN])))
      else $error("protocol strap not applied");

   chk_aux_swap: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults |=> o_aux_is_i2c == !$past(snap[RSCS_PROTO_PIN]))
      else $error("auxiliary port protocol wrong");

   chk_addr_none: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && i_addr_assign == '0 |=> !addr_q)
      else $error("address bit set with no address pin");

   chk_addr_top: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && i_addr_assign[NUM_PINS-1] |=> addr_q == $past(snap[NUM_PINS-1]))
      else $error("highest address pin not used");

   // checks: configuration index
   chk_default_idx: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && no_sel |=> idx_q == $past(SEL_W'(snap[3:0])))
      else $error("default index wrong");

   chk_sel_lsb: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && i_sel_assign[0] |=> idx_q[0] == $past(snap[0]))
      else $error("lowest select pin not the index lsb");

   chk_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && !no_sel && $countones(i_sel_assign) < SEL_W
      |=> (idx_q >> $past($countones(i_sel_assign))) == '0)
      else $error("upper index bits not zero");

   // checks: eeprom search
   chk_eeprom_or: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && eeprom_dis |=> !eesrch_q)
      else $error("eeprom disable ignored");

   chk_eeprom_none: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && i_eedis_assign == '0 |=> eesrch_q)
      else $error("eeprom search off with no disable pin");

   // checks: start-up order and loading
   chk_unprog_skip: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && !i_programmed |=> st_q == RSCS_ST_CLOCKS)
      else $error("load on unprogrammed part");

   chk_load_req: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults && i_programmed |=> o_cfg_load_req)
      else $error("programmed part not loading");

   chk_defaults_once: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults |=> !in_defaults)
      else $error("defaults step repeated");

   chk_load_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_cfg_load_req && !i_cfg_done |=> o_cfg_load_req)
      else $error("load abandoned early");

   chk_bad_csum: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      st_q == RSCS_ST_LOAD && i_cfg_done && !i_cfg_csum_ok |=> !applied_q && out_en_q == '0)
      else $error("bad checksum config applied");

   chk_good_csum: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cfg_take && i_cfg_wr |=> applied_q && out_en_q == $past(i_cfg_out_en))
      else $error("good config not applied");

   chk_cfg_proto: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cfg_take && i_cfg_wr |=> main_i2c_q == $past(i_cfg_main_i2c))
      else $error("loaded protocol not applied");

   chk_cfg_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cfg_take && i_cfg_wr |=> addr_q == $past(i_cfg_addr_bit))
      else $error("loaded address bit not applied");

   chk_cfg_gpio: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cfg_take && i_cfg_wr |=> gpio_mode_q == $past(i_cfg_gpio_out))
      else $error("loaded pin modes not applied");

   chk_cfg_nowr: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      cfg_take && !i_cfg_wr |=> applied_q && $stable(out_en_q))
      else $error("empty config changed outputs");

   chk_applied_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      applied_q |=> applied_q)
      else $error("applied flag dropped");

   chk_outs_off: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      in_defaults |=> out_en_q == '0 && gpio_mode_q == '0)
      else $error("defaults not neutral");

   chk_sw_refused: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sw_wr && (st_q == RSCS_ST_CLOCKS || st_q == RSCS_ST_PLL) |=> $stable(main_i2c_q))
      else $error("software write taken before run");

   chk_sw_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sw_wr && o_startup_done |=> main_i2c_q == $past(i_sw_main_i2c))
      else $error("software protocol write lost");

   chk_sw_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sw_wr && o_startup_done |=> addr_q == $past(i_sw_addr_bit))
      else $error("software address write lost");

   chk_regs_off: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      st_q == RSCS_ST_RESET |-> !o_regulators_en && !o_cfg_load_req)
      else $error("start-up began before capture");

   chk_pll_order: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      st_q == RSCS_ST_CLOCKS && i_clocks_ready |=> o_pll_cal_start)
      else $error("pll step skipped");

   chk_run_after: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      st_q == RSCS_ST_PLL && i_pll_locked |=> o_startup_done)
      else $error("run not reached after lock");
endmodule

// file: test/rscs_strap_model.sv
`timescale 1ns/1ps
module rscs_strap_model (
   // reset seen by the board
   input wire logic i_rstn,
   // strap drive, an undriven pin floats to its pull-up
   input wire logic [15:0] i_drv_en,
   input wire logic [15:0] i_drv_val,
   // pins into the device
   output logic [15:0] o_pins
);
   wire logic [15:0] pulled = (i_drv_en & i_drv_val) | ~i_drv_en;
   assign o_pins = pulled | {7'h00, ~i_rstn, 8'h00};
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rscs_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   wire logic [15:0] i_gpio_pins;
   logic [15:0] drv_en, drv_val, eff, i_sel_assign, i_addr_assign, i_eedis_assign, i_cfg_gpio_out;
   logic i_programmed, i_cfg_done, i_cfg_csum_ok, i_clocks_ready, i_pll_locked, i_sw_wr;
   logic i_sw_main_i2c, i_sw_addr_bit, i_cfg_wr, i_cfg_main_i2c, i_cfg_addr_bit;
   logic [11:0] i_cfg_out_en, o_out_en;
   logic o_main_is_i2c, o_aux_is_i2c, o_slave_addr_bit_two, o_eeprom_search_en, o_cfg_load_req;
   logic o_cfg_applied, o_regs_default, o_regulators_en, o_pll_cal_start, o_startup_done;
   logic [3:0] o_stored_config_set;
   logic [15:0] o_gpio_out_mode;
   int err_count = 0;
   int n_checks = 0;
   integer seed = 32'hc971ff05;
   always #20 i_sys_clk = ~i_sys_clk;
   rscs_strap_model rscs_strap_model_i (.i_rstn, .i_drv_en(drv_en), .i_drv_val(drv_val),
      .o_pins(i_gpio_pins));
   rscs_top rscs_top_i (.i_sys_clk, .i_rstn, .i_gpio_pins, .i_programmed, .i_sel_assign,
      .i_addr_assign, .i_eedis_assign, .i_cfg_done, .i_cfg_csum_ok, .i_clocks_ready,
      .i_pll_locked, .i_sw_wr, .i_sw_main_i2c, .i_sw_addr_bit, .i_cfg_wr, .i_cfg_main_i2c,
      .i_cfg_addr_bit, .i_cfg_out_en, .i_cfg_gpio_out, .o_main_is_i2c, .o_aux_is_i2c,
      .o_slave_addr_bit_two, .o_eeprom_search_en, .o_cfg_load_req, .o_stored_config_set,
      .o_cfg_applied, .o_regs_default, .o_out_en, .o_gpio_out_mode, .o_regulators_en,
      .o_pll_cal_start, .o_startup_done);
   function automatic logic [15:0] rnd16();
      return 16'($random(seed));
   endfunction
   function automatic logic [3:0] exp_idx(input logic [15:0] p, input logic [15:0] m);
      logic [3:0] r;
      int k;
      r = 4'h0;
      k = 0;
      if (m == 16'h0000) return p[3:0];
      for (int i = 0; i < 16; i++) if (m[i] && k < 4) begin
         r[k] = p[i];
         k++;
      end
      return r;
   endfunction
   // last assigned pin wins, so the scan runs upward
   function automatic logic exp_addr(input logic [15:0] p, input logic [15:0] m);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 16; i++) if (m[i]) r = p[i];
      return r;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset(input int mode, input logic prog);
      i_rstn = 1'b0;
      i_programmed = prog;
      drv_en = (mode == 0) ? 16'h0000 : rnd16();
      drv_val = rnd16() | 16'h0100;
      case (mode)
         0: {i_sel_assign, i_addr_assign, i_eedis_assign} = 48'h0;
         1: {i_sel_assign, i_addr_assign, i_eedis_assign} = 48'h0164_0880_3000;
         default: begin
            i_sel_assign = rnd16() & rnd16() & 16'hfcff;
            i_addr_assign = rnd16() & rnd16() & ~i_sel_assign & 16'hfcff;
            i_eedis_assign = rnd16() & rnd16() & ~i_sel_assign & ~i_addr_assign;
         end
      endcase
      repeat (3) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      eff = (drv_en & drv_val) | ~drv_en;
      repeat (6) @(negedge i_sys_clk);
   endtask
   task automatic check_straps;
      check(o_main_is_i2c, eff[9]);
      check(o_aux_is_i2c, !eff[9]);
      check(o_stored_config_set, exp_idx(eff, i_sel_assign));
      check(o_slave_addr_bit_two, exp_addr(eff, i_addr_assign));
      check(o_eeprom_search_en, ~|(eff & i_eedis_assign));
   endtask
   initial begin
      {i_programmed, i_cfg_done, i_cfg_csum_ok, i_clocks_ready, i_pll_locked, i_sw_wr} = 6'h00;
      {i_sw_main_i2c, i_sw_addr_bit, i_cfg_wr, i_cfg_main_i2c, i_cfg_addr_bit} = 5'h00;
      {i_cfg_out_en, i_cfg_gpio_out, drv_en, drv_val} = 60'h0;
      {i_sel_assign, i_addr_assign, i_eedis_assign} = 48'h0;
      @(negedge i_sys_clk);
      for (int t = 0; t < 24; t++) begin
         do_reset((t < 2) ? t : 2, 1'b0);
         check_straps();
         check(o_out_en, 12'h000);
         check(o_gpio_out_mode, 16'h0000);
         check(o_regs_default, 1'b1);
         check(o_cfg_load_req, 1'b0);
         drv_en = rnd16();
         drv_val = rnd16();
         i_sw_main_i2c = !eff[9];
         i_sw_addr_bit = !exp_addr(eff, i_addr_assign);
         i_sw_wr = 1'b1;
         @(negedge i_sys_clk);
         i_sw_wr = 1'b0;
         repeat (3) @(negedge i_sys_clk);
         check_straps();
      end
      for (int g = 0; g < 3; g++) begin
         do_reset(2, 1'b1);
         check(o_cfg_load_req, 1'b1);
         {i_cfg_addr_bit, i_cfg_out_en, i_cfg_gpio_out} = 29'($random(seed));
         i_cfg_main_i2c = ~eff[9];
         i_cfg_csum_ok = (g != 0);
         i_cfg_done = 1'b1;
         i_cfg_wr = (g == 2);
         @(negedge i_sys_clk);
         i_cfg_done = 1'b0;
         i_cfg_wr = 1'b0;
         @(negedge i_sys_clk);
         if (g != 2) begin
            check_straps();
            check(o_regs_default, g == 0);
            check(o_out_en, 12'h000);
         end else begin
            check(o_main_is_i2c, !eff[9]);
            check(o_slave_addr_bit_two, i_cfg_addr_bit);
            check(o_out_en, i_cfg_out_en);
            check(o_gpio_out_mode, i_cfg_gpio_out);
            check(o_cfg_applied, 1'b1);
         end
      end
      i_clocks_ready = 1'b1;
      for (int k = 0; k < 20 && o_pll_cal_start !== 1'b1; k++) @(negedge i_sys_clk);
      check(o_pll_cal_start, 1'b1);
      check(o_regulators_en, 1'b1);
      i_pll_locked = 1'b1;
      for (int k = 0; k < 20 && o_startup_done !== 1'b1; k++) @(negedge i_sys_clk);
      check(o_startup_done, 1'b1);
      i_sw_main_i2c = eff[9];
      i_sw_addr_bit = ~i_cfg_addr_bit;
      i_sw_wr = 1'b1;
      @(negedge i_sys_clk);
      i_sw_wr = 1'b0;
      @(negedge i_sys_clk);
      check(o_main_is_i2c, eff[9]);
      check(o_aux_is_i2c, !eff[9]);
      check(o_slave_addr_bit_two, !i_cfg_addr_bit);
      tally_and_finish();
   end
   // the full run needs under a thousand cycles
   initial begin
      #400000;
      err_count++;
      tally_and_finish();
   end
endmodule
